// >>> rtl/pcc_pkg.sv
// Constants for the loop-derived core clock control block.
// Assumes clk stands in for the loop output and that crystal ticks arrive synchronous to it.
package pcc_pkg;

  // Control register location and reset value
  localparam logic [7:0] PLL_CLOCK_CONTROL_ADDR  = 8'hd7;
  localparam logic [7:0] PLL_CLOCK_CONTROL_RESET = 8'h03;

  // Field positions
  localparam int unsigned HALT_BIT = 7;
  localparam int unsigned LOCK_BIT = 6;
  localparam int unsigned RSV_HI   = 5;
  localparam int unsigned RSV_LO   = 4;
  localparam int unsigned FAST_BIT = 3;
  localparam int unsigned DIV_MSB  = 2;
  localparam int unsigned DIV_LSB  = 0;

  // Divider geometry
  localparam int unsigned DIV_W         = 3;
  localparam int unsigned CNT_W         = 7;
  localparam logic [2:0]  FULL_RATE_DIV = 3'h0;

  // Frequencies
  localparam int unsigned CRYSTAL_HZ = 32768;
  localparam int unsigned PLL_MULT   = 512;
  localparam int unsigned SYS_HZ     = CRYSTAL_HZ * PLL_MULT;
  localparam int unsigned CLK_HZ     = 25000000;

  // Lock check timing, in clk cycles
  localparam int unsigned FREE_RUN_TOL_PCT = 20;
  localparam int unsigned PERIOD_CYCLES    = CLK_HZ / CRYSTAL_HZ;
  localparam int unsigned MIN_GAP_CYCLES   = (PERIOD_CYCLES * (100 - FREE_RUN_TOL_PCT)) / 100;
  localparam int unsigned MAX_GAP_CYCLES   = (PERIOD_CYCLES * (100 + FREE_RUN_TOL_PCT)) / 100;
  localparam int unsigned LOSS_PERIODS     = 2;
  localparam int unsigned LOSS_CYCLES      = PERIOD_CYCLES * LOSS_PERIODS;
  localparam int unsigned LOCK_TICKS       = 4;
  localparam int unsigned GAP_W            = 11;
  localparam int unsigned GOOD_W           = 3;

  typedef enum logic [1:0] {
    LK_ACQUIRE,
    LK_FREE,
    LK_LOCKED,
    LK_RAILED
  } pcc_lock_state_t;

endpackage : pcc_pkg

// >>> rtl/pcc_lock_monitor.sv
// Loop lock tracker: judges crystal presence after reset and watches for later loss.
// Assumes crystal_tick is a one-cycle pulse per crystal period, synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module pcc_lock_monitor (
  // Clock and synchronised reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Crystal
  input  wire logic crystal_tick,
  // Status
  output logic      locked,
  output logic      railed
);

  typedef struct packed {
    pcc_pkg::pcc_lock_state_t           state;
    logic [pcc_pkg::GAP_W-1:0]          gap;
    logic [pcc_pkg::GOOD_W-1:0]         good;
    logic                               locked;
    logic                               railed;
  } pcc_lock_reg_t;

  localparam logic [pcc_pkg::GAP_W-1:0]  MIN_GAP = pcc_pkg::GAP_W'(pcc_pkg::MIN_GAP_CYCLES);
  localparam logic [pcc_pkg::GAP_W-1:0]  MAX_GAP = pcc_pkg::GAP_W'(pcc_pkg::MAX_GAP_CYCLES);
  localparam logic [pcc_pkg::GAP_W-1:0]  LOSS    = pcc_pkg::GAP_W'(pcc_pkg::LOSS_CYCLES);
  localparam logic [pcc_pkg::GOOD_W-1:0] NEED    = pcc_pkg::GOOD_W'(pcc_pkg::LOCK_TICKS);

  pcc_lock_reg_t st;
  pcc_lock_reg_t next_st;

  always_comb
  begin
    next_st = st;
    if (crystal_tick)
      next_st.gap = '0;
    else if (st.gap != LOSS)
      next_st.gap = st.gap + 1'b1;
    case (st.state)
      pcc_pkg::LK_ACQUIRE:
      begin
        // Out-of-band tick spacing means no usable crystal: free-run
        if (crystal_tick && st.good != '0 && (st.gap < MIN_GAP || st.gap > MAX_GAP))
          next_st.state = pcc_pkg::LK_FREE;
        else if (!crystal_tick && st.gap >= MAX_GAP)
          next_st.state = pcc_pkg::LK_FREE;
        else if (crystal_tick)
        begin
          next_st.good = st.good + 1'b1;
          if (st.good + 1'b1 == NEED)
          begin
            next_st.state  = pcc_pkg::LK_LOCKED;
            next_st.locked = 1'b1;
          end
        end
      end
      pcc_pkg::LK_LOCKED:
      begin
        if (!crystal_tick && st.gap == LOSS)
        begin
          next_st.state  = pcc_pkg::LK_RAILED;
          next_st.railed = 1'b1;
        end
      end
      // Free-run and railed hold until the next reset: lock is judged at power-on only
      pcc_pkg::LK_FREE:   next_st.locked = 1'b0;
      pcc_pkg::LK_RAILED: next_st.railed = 1'b1;
      default:            next_st.state  = pcc_pkg::LK_ACQUIRE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{pcc_pkg::LK_ACQUIRE, '0, '0, 1'b0, 1'b0};
    else
      st <= next_st;
  end

  assign locked = st.locked;
  assign railed = st.railed;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_free_never_lock: assert property (st.state == pcc_pkg::LK_FREE |=> !locked)
    else $error("lock status set while free-running");

  a_loss_to_rail: assert property (
    st.state == pcc_pkg::LK_LOCKED && st.gap == LOSS && !crystal_tick |=> railed && locked)
    else $error("crystal loss after lock did not rail the loop");

endmodule : pcc_lock_monitor

`default_nettype wire

// >>> rtl/pcc_core_clock_control.sv
// Core clock control: control register, binary core divider, fast interrupt override,
// crystal oscillator power-down control and lock status.
// Assumes a special-function-register port synchronous to clk, which stands for the loop output;
// core_clk_en is the divided core clock as a one-cycle enable for the core's flops.
//
// Operation
// - The loop multiplies the 32.768 kHz crystal by 512 to a 16.777216 MHz system clock.
// - The core clock is the loop output divided by two to the power of the divider field.
// - After reset the divider selects divide by 8 and the control register reads 0x03.
// - With the oscillator halt bit set, the crystal oscillator stops during power-down.
// - With that bit clear, the oscillator keeps running in power-down for the interval counter.
// - Bit 6 is a read-only lock flag set at power-on when the loop tracks the crystal.
// - Without tracking at power-on the lock flag reads zero and the loop free-runs.
// - Losing the crystal after lock rails the loop and stops the core clock.
// - With the fast interrupt bit set, interrupt service runs at the undivided rate.
// - On return from the interrupt the divider setting applies again; clearing the bit ends it.
// - The three-bit divider field in bits 2 to 0 sets the core operating frequency.
// - Divider 000 gives 16.777216 MHz and each step halves it, down to 0.131072 MHz at 111.
// - The interval counter is clocked from the crystal oscillator, not the loop.
`timescale 1ns/100ps
`default_nettype none

module pcc_core_clock_control (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Core and system status
  input  wire logic       irq_in_service,
  input  wire logic       power_down,
  output logic            core_clk_en,
  output logic            core_halted,
  // Crystal and interval counter
  input  wire logic       crystal_tick,
  output logic            crystal_osc_run,
  output logic            interval_tick
);

  typedef struct packed {
    logic                        crystal_sleep_halt;
    logic                        fast_irq_clocking;
    logic [pcc_pkg::DIV_W-1:0]   core_divider;
    logic [pcc_pkg::DIV_W-1:0]   active_div;
    logic [pcc_pkg::CNT_W-1:0]   cnt;
    logic                        pulse;
    logic                        halted;
    logic                        osc_run;
    logic                        tick_out;
    logic [7:0]                  rdata;
  } pcc_core_reg_t;

  // Period mask for a divider setting: the count at which the period ends
  function automatic logic [pcc_pkg::CNT_W-1:0] div_mask(input logic [pcc_pkg::DIV_W-1:0] d);
    logic [pcc_pkg::CNT_W:0] one_hot;
    one_hot  = '0;
    one_hot  = (pcc_pkg::CNT_W+1)'(1) << d;
    div_mask = pcc_pkg::CNT_W'(one_hot - 1'b1);
  endfunction : div_mask

  logic          rst_meta_n;
  logic          rst_sync_n;
  logic          locked;
  logic          railed;
  logic          fast_sel;
  logic          stopped;
  logic [2:0]    sel_div;
  pcc_core_reg_t st;
  pcc_core_reg_t next_st;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  pcc_lock_monitor u_lock (
    .clk          (clk),
    .rst_n        (rst_sync_n),
    .crystal_tick (crystal_tick),
    .locked       (locked),
    .railed       (railed)
  );

  always_comb
  begin
    next_st  = st;
    fast_sel = st.fast_irq_clocking & irq_in_service;
    sel_div  = fast_sel ? pcc_pkg::FULL_RATE_DIV : st.core_divider;
    stopped  = railed | power_down;

    // Register write; lock flag and reserved bits are not stored
    if (sfr_wr && sfr_addr == pcc_pkg::PLL_CLOCK_CONTROL_ADDR)
    begin
      next_st.crystal_sleep_halt = sfr_wdata[pcc_pkg::HALT_BIT];
      next_st.fast_irq_clocking  = sfr_wdata[pcc_pkg::FAST_BIT];
      next_st.core_divider       = sfr_wdata[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB];
    end

    // Register read; unmapped addresses read zero
    if (sfr_rd)
    begin
      next_st.rdata = 8'h00;
      if (sfr_addr == pcc_pkg::PLL_CLOCK_CONTROL_ADDR)
      begin
        next_st.rdata[pcc_pkg::HALT_BIT]                  = st.crystal_sleep_halt;
        next_st.rdata[pcc_pkg::LOCK_BIT]                  = locked;
        next_st.rdata[pcc_pkg::FAST_BIT]                  = st.fast_irq_clocking;
        next_st.rdata[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB]  = st.core_divider;
      end
    end

    // Divider: a new setting is taken only where the running period ends, so no
    // period is ever cut short; the price is up to one old period of latency
    next_st.pulse = 1'b0;
    if (!stopped)
    begin
      if (st.cnt == div_mask(st.active_div))
      begin
        next_st.pulse      = 1'b1;
        next_st.cnt        = '0;
        next_st.active_div = sel_div;
      end
      else
        next_st.cnt = st.cnt + 1'b1;
    end
    next_st.halted = stopped;

    // Crystal oscillator and interval counter clock
    next_st.osc_run  = !(power_down && st.crystal_sleep_halt);
    next_st.tick_out = crystal_tick & st.osc_run;
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      st <= '{pcc_pkg::PLL_CLOCK_CONTROL_RESET[pcc_pkg::HALT_BIT],
              pcc_pkg::PLL_CLOCK_CONTROL_RESET[pcc_pkg::FAST_BIT],
              pcc_pkg::PLL_CLOCK_CONTROL_RESET[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB],
              pcc_pkg::PLL_CLOCK_CONTROL_RESET[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB],
              '0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00};
    else
      st <= next_st;
  end

  assign sfr_rdata       = st.rdata;
  assign core_clk_en     = st.pulse;
  assign core_halted     = st.halted;
  assign crystal_osc_run = st.osc_run;
  assign interval_tick   = st.tick_out;

  // Helper: running cycles since the last core clock pulse
  logic [pcc_pkg::CNT_W:0] run_gap;
  logic                    seen_pulse;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      run_gap    <= '0;
      seen_pulse <= 1'b0;
    end
    else
    begin
      if (!stopped)
        run_gap <= core_clk_en ? (pcc_pkg::CNT_W+1)'(1) : run_gap + 1'b1;
      else if (core_clk_en)
        run_gap <= '0;
      if (core_clk_en)
        seen_pulse <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_fast_entry;
    $rose(fast_sel) && !stopped;
  endsequence

  sequence s_irq_return;
    $fell(irq_in_service) && st.fast_irq_clocking && !stopped && st.active_div == 3'h0;
  endsequence

  a_reset_div_eight: assert property ($rose(rst_sync_n) |-> st.core_divider == 3'h3
    && st.active_div == 3'h3)
    else $error("divider not at divide by 8 after reset");

  a_period_length: assert property (core_clk_en && seen_pulse |->
    run_gap == {1'b0, div_mask($past(st.active_div))} + 1'b1)
    else $error("core clock period does not match divider");

  a_fast_entry_rate: assert property (s_fast_entry |->
    ##[1:130] (st.active_div == 3'h0 || !fast_sel || stopped))
    else $error("fast interrupt override not reached");

  a_return_rate: assert property (s_irq_return |=> st.active_div == $past(st.core_divider))
    else $error("divider rate not restored after interrupt return");

  a_lock_read_only: assert property (sfr_wr && sfr_rd
    && sfr_addr == pcc_pkg::PLL_CLOCK_CONTROL_ADDR
    |=> sfr_rdata[pcc_pkg::LOCK_BIT] == $past(locked))
    else $error("lock bit follows write data");

  a_read_layout: assert property (sfr_rd && sfr_addr == pcc_pkg::PLL_CLOCK_CONTROL_ADDR |=>
    sfr_rdata[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB] == $past(st.core_divider)
    && sfr_rdata[pcc_pkg::RSV_HI:pcc_pkg::RSV_LO] == 2'h0)
    else $error("control register read layout wrong");

  a_osc_halt_pd: assert property (power_down && st.crystal_sleep_halt |=> !crystal_osc_run)
    else $error("oscillator kept running in power-down with halt set");

  a_osc_keep_pd: assert property (power_down && !st.crystal_sleep_halt |=> crystal_osc_run)
    else $error("oscillator stopped in power-down with halt clear");

  a_interval_clock: assert property (interval_tick |-> $past(crystal_tick)
    && $past(crystal_osc_run))
    else $error("interval tick without running crystal");

  a_rail_stops_core: assert property (railed |=> !core_clk_en && core_halted)
    else $error("core clock runs with railed loop");

  // Register side
  sequence s_ctrl_write;
    sfr_wr && sfr_addr == pcc_pkg::PLL_CLOCK_CONTROL_ADDR;
  endsequence

  sequence s_ctrl_read;
    sfr_rd && sfr_addr == pcc_pkg::PLL_CLOCK_CONTROL_ADDR;
  endsequence

  a_write_fields: assert property (s_ctrl_write |=>
    st.core_divider == $past(sfr_wdata[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB])
    && st.fast_irq_clocking == $past(sfr_wdata[pcc_pkg::FAST_BIT])
    && st.crystal_sleep_halt == $past(sfr_wdata[pcc_pkg::HALT_BIT]))
    else $error("control register write not stored");

  a_foreign_write: assert property (
    sfr_wr && sfr_addr != pcc_pkg::PLL_CLOCK_CONTROL_ADDR |=> $stable(st.core_divider)
    && $stable(st.fast_irq_clocking) && $stable(st.crystal_sleep_halt))
    else $error("write to another address changed the control register");

  a_lock_reads: assert property (s_ctrl_read |=>
    sfr_rdata[pcc_pkg::LOCK_BIT] == $past(locked))
    else $error("lock flag not reported on read");

  // Divider and override
  // A new setting is only taken at a period end, so the count never overruns it
  sequence s_period_end;
    !stopped && st.cnt == div_mask(st.active_div);
  endsequence

  a_period_pulse: assert property (s_period_end |=> core_clk_en && st.cnt == '0)
    else $error("period end without core clock pulse");

  a_pulse_single: assert property (core_clk_en
    && st.active_div != pcc_pkg::FULL_RATE_DIV |=> !core_clk_en)
    else $error("core clock pulse longer than one cycle");

  a_stop_no_pulse: assert property (stopped |=> !core_clk_en && core_halted)
    else $error("core clock pulse while stopped");

  a_full_rate_run: assert property (!stopped && st.active_div == pcc_pkg::FULL_RATE_DIV
    |=> core_clk_en)
    else $error("full rate selected but a cycle had no core clock pulse");

  a_switch_at_end: assert property (!stopped && st.cnt != div_mask(st.active_div)
    |=> $stable(st.active_div))
    else $error("divider switched inside a running period");

  a_count_in_range: assert property (st.cnt <= div_mask(st.active_div))
    else $error("period counter beyond its end point");

  a_fast_select: assert property (!stopped && fast_sel
    && st.cnt == div_mask(st.active_div) |=> st.active_div == pcc_pkg::FULL_RATE_DIV)
    else $error("fast interrupt override not taken at period end");

  a_divider_load: assert property (!stopped && !fast_sel
    && st.cnt == div_mask(st.active_div) |=> st.active_div == $past(st.core_divider))
    else $error("register divider not taken at period end");

  // Crystal side
  a_osc_awake: assert property (!power_down |=> crystal_osc_run)
    else $error("oscillator stopped outside power-down");

  a_tick_passes: assert property (crystal_tick && crystal_osc_run |=> interval_tick)
    else $error("crystal tick not passed to the interval counter");

endmodule : pcc_core_clock_control

`default_nettype wire

// >>> testbench/pcc_crystal_model.sv
// Watch crystal model: one-cycle tick per crystal period while the crystal is fitted.
// Assumes clk stands for the loop output, so a period is a fixed count of clk cycles.
`timescale 1ns/100ps
`default_nettype none

module pcc_crystal_model #(
  parameter int unsigned PERIOD = pcc_pkg::PERIOD_CYCLES
) (
  // Clock
  input  wire logic clk,
  // Crystal fitted
  input  wire logic present,
  // Crystal tick
  output logic      crystal_tick
);
  logic [15:0] phase = 16'h0000;

  // Free-running phase, so removing the crystal mid-period never leaves a short gap between ticks
  always_ff @(posedge clk)
  begin
    phase        <= (phase == 16'(PERIOD - 1)) ? 16'h0000 : phase + 16'h0001;
    crystal_tick <= present && (phase == 16'h0000);
  end
endmodule : pcc_crystal_model

`default_nettype wire

// >>> testbench/pcc_core_clock_control_bench.sv
// Testbench for the core clock control: register, divider, fast override, power-down, lock.
// Assumes the crystal model ticks every PERIOD_CYCLES clocks while present is high.
`timescale 1ns/100ps
`default_nettype none

module pcc_core_clock_control_bench;
  logic       clk            = 1'b0;
  logic       rst_n          = 1'b0;
  logic [7:0] sfr_addr       = 8'h00;
  logic       sfr_wr         = 1'b0;
  logic       sfr_rd         = 1'b0;
  logic [7:0] sfr_wdata      = 8'h00;
  logic [7:0] sfr_rdata;
  logic       irq_in_service = 1'b0;
  logic       power_down     = 1'b0;
  logic       core_clk_en;
  logic       core_halted;
  logic       crystal_tick;
  logic       crystal_osc_run;
  logic       interval_tick;
  logic       present        = 1'b1;
  int         err_count      = 0;
  int         check_count    = 0;
  int         ti;
  int         ce;

  always #20 clk = ~clk;

  pcc_core_clock_control pcc_core_clock_control_inst (
    .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_in_service(irq_in_service),
    .power_down(power_down), .core_clk_en(core_clk_en), .core_halted(core_halted),
    .crystal_tick(crystal_tick), .crystal_osc_run(crystal_osc_run),
    .interval_tick(interval_tick)
  );

  pcc_crystal_model pcc_crystal_model_inst (
    .clk(clk), .present(present), .crystal_tick(crystal_tick)
  );

  task automatic stop_test();
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    @(negedge clk);
    chk(what, {24'h0, exp}, {24'h0, sfr_rdata});
  endtask : rd

  // Write and read in one cycle: the read returns the value held before the write
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp,
                       input string what);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    sfr_rd    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    @(negedge clk);
    chk(what, {24'h0, exp}, {24'h0, sfr_rdata});
  endtask : wr_rd

  // Cycles up to the next core enable pulse; bounded so a stopped clock cannot hang
  task automatic pulse(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (core_clk_en !== 1'b1 && n < 300);
  endtask : pulse

  // Two periods are skipped since a new setting waits for the running period to end
  task automatic period(input int exp);
    int n;
    pulse(n);
    pulse(n);
    pulse(n);
    chk("core period", 32'(exp), 32'(n));
  endtask : period

  task automatic count(input int cyc);
    ti = 0;
    ce = 0;
    repeat (cyc)
    begin
      @(negedge clk);
      ti += (interval_tick === 1'b1) ? 1 : 0;
      ce += (core_clk_en === 1'b1) ? 1 : 0;
    end
  endtask : count

  initial
  begin
    do_reset();
    rd(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h03, "reset value");
    period(8);
    repeat (5000) @(negedge clk);
    rd(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h43, "locked value");
    wr_rd(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h00, 8'h43, "read during write");
    wr(8'h55, 8'h07);
    rd(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h40, "lock after write");
    rd(8'h55, 8'h00, "unmapped read");
    for (int k = 0; k < 8; k++)
    begin
      wr(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'(k));
      period(1 << k);
    end
    wr(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h8f);
    rd(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'hcf, "lock read-only");
    wr(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h0b);
    irq_in_service = 1'b1;
    period(1);
    irq_in_service = 1'b0;
    period(8);
    wr(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h03);
    irq_in_service = 1'b1;
    period(8);
    irq_in_service = 1'b0;
    wr(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h83);
    power_down = 1'b1;
    repeat (2) @(negedge clk);
    count(1200);
    chk("osc run", 32'h0, {31'h0, crystal_osc_run});
    chk("interval ticks", 32'h0, 32'(ti));
    chk("halted", 32'h1, {31'h0, core_halted});
    chk("pulses in power-down", 32'h0, 32'(ce));
    wr(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h03);
    count(1200);
    chk("osc run", 32'h1, {31'h0, crystal_osc_run});
    chk("interval ticks seen", 32'h1, {31'h0, ti > 0});
    power_down = 1'b0;
    period(8);
    wr(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h8e);
    present = 1'b0;
    repeat (1700) @(negedge clk);
    count(300);
    chk("halted after loss", 32'h1, {31'h0, core_halted});
    chk("pulses after loss", 32'h0, 32'(ce));
    do_reset();
    repeat (2000) @(negedge clk);
    rd(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h03, "free-run value");
    period(8);
    present = 1'b1;
    repeat (4000) @(negedge clk);
    rd(pcc_pkg::PLL_CLOCK_CONTROL_ADDR, 8'h03, "late crystal value");
    stop_test();
  end

  // Whole sequence needs about 16500 cycles; this limit leaves ample margin
  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    stop_test();
  end
endmodule : pcc_core_clock_control_bench

`default_nettype wire
